/* File: hw/bod_dir.sv */
// direction handling: inversion taken over at power-on, target sign to motor direction
`timescale 1ns/1ps

module bod_dir #(
  parameter int TGT_W = 32
) (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    srst_in,
  // power-on event and stored setting
  input  wire logic                    power_on_in,
  input  wire bod_pkg::bod_word_t      dir_cfg_in,
  // commanded target
  input  wire logic signed [TGT_W-1:0] target_in,
  // outputs towards the motion core
  output logic                         inv_active_out,
  output logic signed [TGT_W-1:0]      target_eff_out,
  output logic                         dir_pos_out,
  output logic                         dir_neg_out
);
  import bod_pkg::*;

  logic                    inv_active, next_inv_active;
  logic signed [TGT_W-1:0] target_eff, next_target_eff;
  logic                    dir_pos, next_dir_pos;
  logic                    dir_neg, next_dir_neg;

  ////////////////////////////////////////////////////////////////////////////////
  // the stored code governs only after the next power-on, so a live change
  // cannot flip the axis under a running move
  always_comb begin
    next_inv_active = inv_active;
    if (power_on_in) begin
      next_inv_active = (dir_cfg_in == `BOD_DIR_ON);
    end
    // note: the most negative target cannot be mirrored and stays as is
    next_target_eff = inv_active ? -target_in : target_in;
    next_dir_pos    = (next_target_eff > 0);  // positive means clockwise
    next_dir_neg    = (next_target_eff < 0);
  end

  // register stage
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      inv_active <= 1'b0;
      target_eff <= '0;
      dir_pos    <= 1'b0;
      dir_neg    <= 1'b0;
    end else begin
      inv_active <= next_inv_active;
      target_eff <= next_target_eff;
      dir_pos    <= next_dir_pos;
      dir_neg    <= next_dir_neg;
    end
  end

  assign inv_active_out = inv_active;
  assign target_eff_out = target_eff;
  assign dir_pos_out    = dir_pos;
  assign dir_neg_out    = dir_neg;

endmodule : bod_dir

/* File: hw/bod_regs.sv */
// parameter store: brake override and direction inversion registers
`timescale 1ns/1ps

module bod_regs (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              srst_in,
  // parameter access port
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire bod_pkg::bod_word_t addr_in,
  input  wire bod_pkg::bod_word_t wdata_in,
  output bod_pkg::bod_word_t     rdata_out,
  output logic                   ack_out,
  output logic                   err_out,
  // drive status
  input  wire logic              power_en_in,
  // stored values
  output bod_pkg::bod_word_t     brk_code_out,
  output bod_pkg::bod_word_t     dir_cfg_out
);
  import bod_pkg::*;

  bod_word_t brk_code, next_brk_code;
  bod_word_t dir_cfg, next_dir_cfg;
  bod_word_t rdata, next_rdata;
  logic      ack, next_ack;
  logic      err, next_err;

  ////////////////////////////////////////////////////////////////////////////////
  // write checks and read mux; a refused write leaves the old value in place
  always_comb begin
    next_brk_code = brk_code;
    next_dir_cfg  = dir_cfg;
    next_rdata    = rdata;
    next_ack      = 1'b0;
    next_err      = 1'b0;
    if (wr_in) begin
      next_ack = 1'b1;
      if (addr_in == `BOD_OFS_BRK) begin
        if (wdata_in <= `BOD_BRK_MAPP) begin
          next_brk_code = wdata_in;
        end else begin
          next_err = 1'b1;
        end
      end else if (addr_in == `BOD_OFS_DIR) begin
        // the power stage must be off, else the change is refused
        if (!power_en_in && (wdata_in <= `BOD_DIR_ON)) begin
          next_dir_cfg = wdata_in;
        end else begin
          next_err = 1'b1;
        end
      end else begin
        next_err = 1'b1;
      end
    end else if (rd_in) begin
      next_ack = 1'b1;
      case (addr_in)
        `BOD_OFS_BRK: next_rdata = brk_code;
        `BOD_OFS_DIR: next_rdata = dir_cfg;
        default: begin
          next_rdata = `BOD_RD_NONE;
          next_err   = 1'b1;
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      brk_code <= `BOD_BRK_RST;
      dir_cfg  <= `BOD_DIR_RST;
      rdata    <= `BOD_RD_NONE;
      ack      <= 1'b0;
      err      <= 1'b0;
    end else begin
      brk_code <= next_brk_code;
      dir_cfg  <= next_dir_cfg;
      rdata    <= next_rdata;
      ack      <= next_ack;
      err      <= next_err;
    end
  end

  assign brk_code_out = brk_code;
  assign dir_cfg_out  = dir_cfg;
  assign rdata_out    = rdata;
  assign ack_out      = ack;
  assign err_out      = err;

endmodule : bod_regs

/* File: hw/bod_top.sv */
// brake override and direction control: brake handling state machine and top level
`timescale 1ns/1ps

// Summary of operation
// - The brake override field uses 0 for automatic, 1 for manual release, 2 for manual apply.
// - Manual release opens the brake only in switch-on-disabled, ready or fault state.
// - After a manual apply, release needs automatic first; apply straight to release does not open.
// - A write to the brake override field acts at once, with no enable or power cycle.
// - The digital input releases the brake only once it is assigned the release function.
// - Inversion off: positive targets move positive; inversion on: negative targets move positive.
// - Positive direction is clockwise rotation seen from the end of the motor shaft.
// - Direction inversion accepts writes only while the power stage is disabled.
// - A changed direction inversion is stored and governs movement only after the next power-on.
// - A manual apply overrides automatic and manual release, even when the power stage is enabled.
// - A manual apply is honoured only while the motor is at a standstill.
// - In automatic handling, disabling the power stage applies the holding brake.
module bod_top #(
  parameter int TGT_W = 32
) (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    srst_in,
  // parameter access port
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire bod_pkg::bod_word_t      reg_addr_in,
  input  wire bod_pkg::bod_word_t      reg_wdata_in,
  output bod_pkg::bod_word_t           reg_rdata_out,
  output logic                         reg_ack_out,
  output logic                         reg_err_out,
  // drive status
  input  wire bod_pkg::bod_ops_t       op_state_in,
  input  wire logic                    power_en_in,
  input  wire logic                    standstill_in,
  input  wire logic                    power_on_in,
  // digital release input
  input  wire logic                    din_release_in,
  input  wire logic                    din_assigned_in,
  // motion command
  input  wire logic signed [TGT_W-1:0] target_in,
  // brake and direction outputs
  output logic                         brake_release_out,
  output logic                         brake_held_out,
  output logic                         inv_active_out,
  output logic signed [TGT_W-1:0]      target_eff_out,
  output logic                         dir_pos_out,
  output logic                         dir_neg_out
);
  import bod_pkg::*;

  // stored codes from the parameter store
  bod_word_t      brk_code;
  bod_word_t      dir_cfg;
  // brake handling state and its registered outputs
  bod_brk_state_t state, next_state;
  logic           release_q, next_release_q;
  logic           held_q, next_held_q;
  // release sources, all plain levels
  logic           man_ok;
  logic           auto_rel;
  logic           man_rel;
  logic           din_rel;

  ////////////////////////////////////////////////////////////////////////////////
  // parameter store
  bod_regs u_regs (
    .mclk_in      (mclk_in),
    .srst_in      (srst_in),
    .wr_in        (reg_wr_in),
    .rd_in        (reg_rd_in),
    .addr_in      (reg_addr_in),
    .wdata_in     (reg_wdata_in),
    .rdata_out    (reg_rdata_out),
    .ack_out      (reg_ack_out),
    .err_out      (reg_err_out),
    .power_en_in  (power_en_in),
    .brk_code_out (brk_code),
    .dir_cfg_out  (dir_cfg)
  );

  // direction path
  bod_dir #(
    .TGT_W (TGT_W)
  ) u_dir (
    .mclk_in        (mclk_in),
    .srst_in        (srst_in),
    .power_on_in    (power_on_in),
    .dir_cfg_in     (dir_cfg),
    .target_in      (target_in),
    .inv_active_out (inv_active_out),
    .target_eff_out (target_eff_out),
    .dir_pos_out    (dir_pos_out),
    .dir_neg_out    (dir_neg_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // brake handling state machine; follows the stored code every cycle so a
  // new code acts without waiting for an enable
  always_comb begin
    next_state = state;
    case (state)
      BOD_ST_AUTO: begin
        // the operating state gate sits at the output, so a release code
        // written early still acts once the drive reaches a permitted state
        if (brk_code == `BOD_BRK_MREL) begin
          next_state = BOD_ST_REL;
        end else if (brk_code == `BOD_BRK_MAPP) begin
          next_state = BOD_ST_PEND;
        end
      end
      BOD_ST_REL: begin
        // leaving release for apply goes through pending, never straight to held
        if (brk_code == `BOD_BRK_AUTO) begin
          next_state = BOD_ST_AUTO;
        end else if (brk_code == `BOD_BRK_MAPP) begin
          next_state = BOD_ST_PEND;
        end
      end
      BOD_ST_PEND: begin
        // apply waits here until the shaft stands still
        if (brk_code == `BOD_BRK_AUTO) begin
          next_state = BOD_ST_AUTO;
        end else if (brk_code == `BOD_BRK_MREL) begin
          next_state = BOD_ST_REL;
        end else if (standstill_in) begin
          next_state = BOD_ST_HELD;
        end
      end
      BOD_ST_HELD: begin
        // only automatic leaves a manual apply; a direct release is ignored
        if (brk_code == `BOD_BRK_AUTO) begin
          next_state = BOD_ST_AUTO;
        end
      end
      default: next_state = BOD_ST_AUTO;
    endcase
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= BOD_ST_AUTO;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // release sources; the brake output is registered to keep it glitch free
  assign man_ok   = bod_manual_ok(op_state_in);
  assign auto_rel = power_en_in;
  assign man_rel  = (state == BOD_ST_REL) && man_ok;
  assign din_rel  = din_assigned_in && din_release_in && man_ok;

  // limitation: the input release shares the manual gate, so it does nothing
  // outside the three permitted operating states
  always_comb begin
    next_held_q    = (state == BOD_ST_HELD);
    // a held manual apply beats every release source
    next_release_q = !next_held_q && (auto_rel || man_rel || din_rel);
  end

  // output register; one cycle of latency buys a brake line free of decode glitches
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      release_q <= 1'b0;
      held_q    <= 1'b0;
    end else begin
      release_q <= next_release_q;
      held_q    <= next_held_q;
    end
  end

  assign brake_release_out = release_q;
  assign brake_held_out    = held_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_wr_brk(bod_word_t code);
    reg_wr_in && (reg_addr_in == `BOD_OFS_BRK) && (reg_wdata_in == code);
  endsequence

  sequence s_wr_dir;
    reg_wr_in && (reg_addr_in == `BOD_OFS_DIR);
  endsequence

  brk_code_range_a: assert property (brk_code <= `BOD_BRK_MAPP)
    else $error("brake override code out of range");

  man_rel_state_a: assert property (
    brake_release_out |-> $past(power_en_in) || $past(man_ok))
    else $error("brake opened with power off outside allowed states");

  apply_to_rel_a: assert property (
    (state == BOD_ST_HELD) && (brk_code == `BOD_BRK_MREL) |=> (state == BOD_ST_HELD))
    else $error("direct change from apply to release left apply");

  write_now_a: assert property (
    s_wr_brk(`BOD_BRK_AUTO) ##1 (!reg_wr_in) |=> (state == BOD_ST_AUTO))
    else $error("automatic code did not take effect at once");

  din_unassigned_a: assert property (
    brake_release_out && !$past(din_assigned_in)
      |-> $past(power_en_in) || ($past(state) == BOD_ST_REL))
    else $error("unassigned input released the brake");

  dir_sign_a: assert property (
    !inv_active_out && !power_on_in && (target_in > 0) |=> dir_pos_out && !dir_neg_out)
    else $error("positive target did not move positive");

  dir_inv_a: assert property (
    inv_active_out && !power_on_in && (target_in < 0) |=> dir_pos_out)
    else $error("inverted negative target did not move clockwise");

  dir_lock_a: assert property (
    (s_wr_dir and power_en_in) |=> reg_err_out && $stable(dir_cfg))
    else $error("inversion changed while power stage enabled");

  dir_defer_a: assert property (
    !power_on_in |=> $stable(inv_active_out))
    else $error("inversion took effect without a power-on");

  apply_prio_a: assert property (
    (state == BOD_ST_HELD) |=> !brake_release_out ##0 brake_held_out)
    else $error("manual apply did not hold the brake");

  apply_standstill_a: assert property (
    (state == BOD_ST_PEND) && !standstill_in |=> (state != BOD_ST_HELD))
    else $error("manual apply taken while moving");

  auto_apply_a: assert property (
    (state == BOD_ST_AUTO) && !power_en_in && !din_rel |=> !brake_release_out)
    else $error("brake not applied after power stage off");

  reject_code_a: assert property (
    reg_wr_in && (reg_addr_in == `BOD_OFS_BRK) && (reg_wdata_in > `BOD_BRK_MAPP)
      |=> reg_err_out && $stable(brk_code))
    else $error("out of range override code was stored");

  // brake path: held state, release gates and the pending step, plus the write acknowledge
  sequence s_apply_wait;
    (state == BOD_ST_PEND) && standstill_in && (brk_code == `BOD_BRK_MAPP);
  endsequence

  sequence s_apply_done;
    (state == BOD_ST_HELD) ##1 brake_held_out;
  endsequence

  held_path_a: assert property (
    (state == BOD_ST_HELD) |=> (state == BOD_ST_HELD) || (state == BOD_ST_AUTO))
    else $error("manual apply left for a state other than automatic");

  rel_gate_a: assert property (
    (state == BOD_ST_REL) && !man_ok && !power_en_in |=> !brake_release_out)
    else $error("manual release opened the brake in a forbidden state");

  rel_write_a: assert property (
    s_wr_brk(`BOD_BRK_MREL) |=> (brk_code == `BOD_BRK_MREL) ##1 (state != BOD_ST_AUTO))
    else $error("release code did not act at once");

  wr_ack_a: assert property (
    reg_wr_in |=> reg_ack_out)
    else $error("write not acknowledged on the next edge");

  din_release_a: assert property (
    (state != BOD_ST_HELD) && din_assigned_in && din_release_in && man_ok
      |=> brake_release_out)
    else $error("assigned input did not release the brake");

  held_flag_a: assert property (
    brake_held_out |-> !brake_release_out)
    else $error("brake released while manual apply held");

  apply_step_a: assert property (
    s_apply_wait |=> s_apply_done)
    else $error("apply at standstill did not engage");

  pend_hold_a: assert property (
    (state == BOD_ST_PEND) |=> !brake_held_out)
    else $error("apply engaged before standstill");

  auto_release_a: assert property (
    (state != BOD_ST_HELD) && power_en_in |=> brake_release_out)
    else $error("enabled power stage did not release the brake");

  // direction and register checks
  dir_write_ok_a: assert property (
    s_wr_dir ##0 !power_en_in ##0 (reg_wdata_in <= `BOD_DIR_ON)
      |=> !reg_err_out && (dir_cfg == $past(reg_wdata_in)))
    else $error("inversion write with power off was not stored");

  inv_load_a: assert property (
    power_on_in |=> (inv_active_out == ($past(dir_cfg) == `BOD_DIR_ON)))
    else $error("power-on did not take over the stored inversion");

  dir_range_a: assert property (dir_cfg <= `BOD_DIR_ON)
    else $error("direction inversion code out of range");

  err_ack_a: assert property (
    reg_err_out |-> reg_ack_out)
    else $error("refusal shown without acknowledge");

endmodule : bod_top

/* File: shared/bod_consts.svh */
// constants for the brake override and direction control block
`ifndef BOD_CONSTS_SVH
`define BOD_CONSTS_SVH

// register offsets on the parameter access port
`define BOD_OFS_DIR      16'h0618
`define BOD_OFS_BRK      16'h0814

// reset values of the stored parameters
`define BOD_DIR_RST      16'h0000
`define BOD_BRK_RST      16'h0000

// brake override codes
`define BOD_BRK_AUTO     16'h0000
`define BOD_BRK_MREL     16'h0001
`define BOD_BRK_MAPP     16'h0002

// direction inversion codes
`define BOD_DIR_OFF      16'h0000
`define BOD_DIR_ON       16'h0001

// operating state codes in which a manual release is allowed
`define BOD_OPS_SOD      4'h3
`define BOD_OPS_RTSO     4'h4
`define BOD_OPS_FAULT    4'h9

// read data for an unmapped address
`define BOD_RD_NONE      16'h0000

`endif

/* File: shared/bod_pkg.sv */
// types and shared decode for the brake override and direction control block
`include "bod_consts.svh"

package bod_pkg;

  // parameter word as seen on the access port
  typedef logic [15:0] bod_word_t;

  // operating state code from the drive state machine
  typedef logic [3:0] bod_ops_t;

  // brake handling states, one-hot
  typedef enum logic [3:0] {
    BOD_ST_AUTO = 4'b0001,
    BOD_ST_REL  = 4'b0010,
    BOD_ST_PEND = 4'b0100,
    BOD_ST_HELD = 4'b1000
  } bod_brk_state_t;

  // states in which a manual release may open the brake
  function automatic logic bod_manual_ok(input bod_ops_t ops);
    bod_manual_ok = (ops == `BOD_OPS_SOD) || (ops == `BOD_OPS_RTSO) ||
                    (ops == `BOD_OPS_FAULT);
  endfunction : bod_manual_ok

endpackage : bod_pkg

/* File: verif/bod_master_model.sv */
// fieldbus master and digital input model that drives the parameter access port
`timescale 1ns/1ps

module bod_master_model (
  // clock
  input  wire logic               mclk_in,
  // parameter access port
  output bod_pkg::bod_word_t      addr_out,
  output bod_pkg::bod_word_t      wdata_out,
  output logic                    wr_out,
  output logic                    rd_out,
  input  wire bod_pkg::bod_word_t rdata_in,
  input  wire logic               ack_in,
  input  wire logic               err_in,
  // digital release input
  output logic                    din_release_out,
  output logic                    din_assigned_out
);
  import bod_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    wr_out           = 1'b0;
    rd_out           = 1'b0;
    addr_out         = 16'h0000;
    wdata_out        = 16'h0000;
    din_release_out  = 1'b0;
    din_assigned_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access: strobe is a single-cycle pulse so it is never taken twice,
  // address and data stay put until the acknowledge is seen
  task automatic access(input logic wr, input bod_word_t addr, input bod_word_t wdata,
                        output bod_word_t rdata, output logic err, output logic seen);
    seen  = 1'b0;
    err   = 1'bx;
    rdata = 16'hxxxx;
    @(negedge mclk_in);
    wr_out    = wr;
    rd_out    = ~wr;
    addr_out  = addr;
    wdata_out = wdata;
    @(negedge mclk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      if (ack_in === 1'b1) begin
        seen  = 1'b1;
        err   = err_in;
        rdata = rdata_in;
      end else begin
        @(negedge mclk_in);
      end
    end
    // released data lines show the inverse, so stale values cannot pass
    wdata_out = ~wdata;
  endtask : access

  ////////////////////////////////////////////////////////////////////////////////
  // input level only counts once the release function is assigned
  task automatic set_din(input logic assigned, input logic level);
    @(negedge mclk_in);
    din_assigned_out = assigned;
    din_release_out  = level;
  endtask : set_din

endmodule : bod_master_model

/* File: verif/test_bod_top.sv */
// self-checking testbench for the brake override and direction control block
`timescale 1ns/1ps
`include "bod_consts.svh"

module test_bod_top;
  import bod_pkg::*;

  localparam int TGT_W = 32;

  logic                    mclk_in = 1'b0;
  logic                    srst_in = 1'b1;
  bod_word_t               addr, wdata, rdata;
  logic                    wr, rd, ack, err;
  bod_ops_t                op_state_in = 4'h0;
  logic                    power_en_in = 1'b0;
  logic                    standstill_in = 1'b1;
  logic                    power_on_in = 1'b0;
  logic                    din_rel, din_asg;
  logic signed [TGT_W-1:0] target_in = 32'sh0;
  logic signed [TGT_W-1:0] teff;
  logic                    brk_rel, brk_held, inv, dpos, dneg;
  int                      fail_count = 0;
  int                      cmp_count = 0;
  bod_ops_t                ops_tab [5] = '{4'h3, 4'h4, 4'h9, 4'h6, 4'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and far-side model
  always #10 mclk_in = ~mclk_in;

  bod_top #(.TGT_W(TGT_W)) i_bod_top (
    .mclk_in(mclk_in), .srst_in(srst_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
    .reg_err_out(err), .op_state_in(op_state_in), .power_en_in(power_en_in),
    .standstill_in(standstill_in), .power_on_in(power_on_in), .din_release_in(din_rel),
    .din_assigned_in(din_asg), .target_in(target_in), .brake_release_out(brk_rel),
    .brake_held_out(brk_held), .inv_active_out(inv), .target_eff_out(teff),
    .dir_pos_out(dpos), .dir_neg_out(dneg));

  bod_master_model i_bod_master_model (
    .mclk_in(mclk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
    .rdata_in(rdata), .ack_in(ack), .err_in(err), .din_release_out(din_rel),
    .din_assigned_out(din_asg));

  ////////////////////////////////////////////////////////////////////////////////
  // checking helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic acc(input logic w, input bod_word_t a, input bod_word_t d, input logic e);
    bod_word_t r;
    logic      er;
    logic      s;
    i_bod_master_model.access(w, a, d, r, er, s);
    chk("ack", 32'h1, {31'h0, s});
    chk("err", {31'h0, e}, {31'h0, er});
    if (!w) chk("rdata", {16'h0, d}, {16'h0, r});
  endtask : acc

  // outputs are only looked at once the stated number of edges has passed
  task automatic brk(input int n, input logic rel, input logic held);
    repeat (n) @(negedge mclk_in);
    chk("brake_release", {31'h0, rel}, {31'h0, brk_rel});
    chk("brake_held", {31'h0, held}, {31'h0, brk_held});
  endtask : brk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the roughly 75 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge mclk_in);
    fail_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(negedge mclk_in);
    srst_in = 1'b0;
    acc(1'b0, `BOD_OFS_DIR, `BOD_DIR_RST, 1'b0);
    acc(1'b0, `BOD_OFS_BRK, `BOD_BRK_RST, 1'b0);
    acc(1'b0, 16'h0700, `BOD_RD_NONE, 1'b1);
    // automatic handling follows the power stage
    op_state_in = `BOD_OPS_RTSO;
    power_en_in = 1'b1;
    brk(1, 1'b1, 1'b0);
    power_en_in = 1'b0;
    brk(1, 1'b0, 1'b0);
    // manual release acts at once, only in the permitted states
    acc(1'b1, `BOD_OFS_BRK, `BOD_BRK_MREL, 1'b0);
    brk(3, 1'b1, 1'b0);
    foreach (ops_tab[i]) begin
      op_state_in = ops_tab[i];
      brk(1, (i < 3), 1'b0);
    end
    op_state_in = `BOD_OPS_RTSO;
    acc(1'b1, `BOD_OFS_BRK, 16'h0003, 1'b1);
    acc(1'b0, `BOD_OFS_BRK, `BOD_BRK_MREL, 1'b0);
    // manual apply waits for standstill, then wins over power enable and manual release
    standstill_in = 1'b0;
    acc(1'b1, `BOD_OFS_BRK, `BOD_BRK_MAPP, 1'b0);
    brk(3, 1'b0, 1'b0);
    standstill_in = 1'b1;
    brk(2, 1'b0, 1'b1);
    power_en_in = 1'b1;
    brk(2, 1'b0, 1'b1);
    power_en_in = 1'b0;
    acc(1'b1, `BOD_OFS_BRK, `BOD_BRK_MREL, 1'b0);
    brk(3, 1'b0, 1'b1);
    acc(1'b1, `BOD_OFS_BRK, `BOD_BRK_AUTO, 1'b0);
    brk(3, 1'b0, 1'b0);
    acc(1'b1, `BOD_OFS_BRK, `BOD_BRK_MREL, 1'b0);
    brk(3, 1'b1, 1'b0);
    // digital input needs its function assigned first
    acc(1'b1, `BOD_OFS_BRK, `BOD_BRK_AUTO, 1'b0);
    i_bod_master_model.set_din(1'b0, 1'b1);
    brk(2, 1'b0, 1'b0);
    i_bod_master_model.set_din(1'b1, 1'b1);
    brk(2, 1'b1, 1'b0);
    i_bod_master_model.set_din(1'b0, 1'b0);
    // inversion refused with power on, stored, taken over at power-on
    power_en_in = 1'b1;
    acc(1'b1, `BOD_OFS_DIR, `BOD_DIR_ON, 1'b1);
    acc(1'b0, `BOD_OFS_DIR, `BOD_DIR_OFF, 1'b0);
    power_en_in = 1'b0;
    acc(1'b1, `BOD_OFS_DIR, 16'h0002, 1'b1);
    acc(1'b1, `BOD_OFS_DIR, `BOD_DIR_ON, 1'b0);
    target_in = -32'sd5;
    repeat (2) @(negedge mclk_in);
    chk("inv_active", 32'h0, {31'h0, inv});
    chk("target_eff", -32'sd5, teff);
    chk("dir_neg", 32'h1, {31'h0, dneg});
    power_on_in = 1'b1;
    @(negedge mclk_in);
    power_on_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk("inv_active", 32'h1, {31'h0, inv});
    chk("target_eff", 32'sd5, teff);
    chk("dir_pos", 32'h1, {31'h0, dpos});
    target_in = 32'sd7;
    repeat (2) @(negedge mclk_in);
    chk("target_eff", -32'sd7, teff);
    chk("dir_neg", 32'h1, {31'h0, dneg});
    stop_test();
  end

endmodule : test_bod_top
